// ---- include/ida_cfg.svh ----
// Purpose: constants for the indirect data addressing block
// Assumes: 12-bit data space, special locations at the top of bank 15
// Notes:   offsets are data-space addresses of the special locations
`ifndef IDA_CFG_SVH
`define IDA_CFG_SVH

// =====================================================
// address space
`define IDA_ADDR_W        12
`define IDA_DATA_W        8
`define IDA_HIGH_W        4
// =====================================================
// pointer and working register locations
`define IDA_OFF_PTR0_HIGH 12'hfea
`define IDA_OFF_PTR0_LOW  12'hfe9
`define IDA_OFF_WORKING   12'hfe8
`define IDA_OFF_PTR1_HIGH 12'hfe2
`define IDA_OFF_PTR1_LOW  12'hfe1
`define IDA_OFF_PTR2_HIGH 12'hfda
`define IDA_OFF_PTR2_LOW  12'hfd9
// =====================================================
// virtual location groups: base of each pointer's group of five
`define IDA_OFF_GRP0      12'hfeb
`define IDA_OFF_GRP1      12'hfe3
`define IDA_OFF_GRP2      12'hfdb
// special function area starts here
`define IDA_OFF_SFR_BASE  12'hf60
// =====================================================
// reset values
`define IDA_RST_HIGH      4'h0
`define IDA_RST_LOW       8'h00
`define IDA_RST_WORKING   8'h00

`endif

// ---- include/ida_pkg.sv ----
// Purpose: types for the indirect data addressing block
// Assumes: nothing beyond the constants header
// Notes:   modes are ordered by offset above each group base
package ida_pkg;
    // access mode picked by the virtual location
    typedef enum logic [2:0] {
        IDA_MODE_OFFSET,
        IDA_MODE_PREINC,
        IDA_MODE_POSTDEC,
        IDA_MODE_POSTINC,
        IDA_MODE_PLAIN,
        IDA_MODE_NONE
    } ida_mode_e;
    // cycle phase of the block
    typedef enum logic [1:0] {
        IDA_ST_IDLE,
        IDA_ST_READ
    } ida_state_e;
endpackage

// ---- rtl/ida_mem.sv ----
// Purpose: general purpose data memory behind the indirect locations
// Assumes: one access per cycle, read data one cycle later
// Notes:   contents are not reset, as for real data ram
`timescale 1ns/10ps
module ida_mem #(
    parameter int ADDR_W = 12,
    parameter int DATA_W = 8,
    parameter int DEPTH  = 3936
) (
    input  wire logic              ref_clk,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [DATA_W-1:0] wdata,
    input  wire logic              we,
    output logic      [DATA_W-1:0] rdata
);
    // =====================================================
    // storage
    logic [DATA_W-1:0] mem [DEPTH];  // data bytes
    logic [DATA_W-1:0] rdata_d;      // next read data

    // read path, out of range reads zero
    always_comb begin
        rdata_d = '0;
        if (int'(addr) < DEPTH) begin
            rdata_d = mem[addr];
        end
    end

    // write and register read data
    always_ff @(posedge ref_clk) begin
        if (we && (int'(addr) < DEPTH)) begin
            mem[addr] <= wdata;
        end
        rdata <= rdata_d;
    end
endmodule

// ---- rtl/ida_top.sv ----
// Purpose: indirect data addressing with three pointers and virtual locations
// Assumes: cpu port, one cycle strobes, read data one cycle after read strobe
// Notes:   ram below the special area sits in ida_mem
`timescale 1ns/10ps
`include "ida_cfg.svh"
module ida_top
    import ida_pkg::*;
#(
    parameter int ADDR_W = `IDA_ADDR_W,
    parameter int DATA_W = `IDA_DATA_W,
    parameter int RAM_D  = 3936
) (
    input  wire logic              ref_clk,
    input  wire logic              rst_n,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [DATA_W-1:0] wdata,
    input  wire logic              wr_stb,
    input  wire logic              rd_stb,
    output logic      [DATA_W-1:0] rdata,
    output logic      [ADDR_W-1:0] ptr0,
    output logic      [ADDR_W-1:0] ptr1,
    output logic      [ADDR_W-1:0] ptr2
);
    // =====================================================
    // state
    logic [ADDR_W-1:0] ptr_q [3];   // pointers
    logic [ADDR_W-1:0] ptr_d [3];   // next pointers
    logic [DATA_W-1:0] work_q;      // working register
    logic [DATA_W-1:0] work_d;      // next working register
    logic [DATA_W-1:0] rdata_q;     // registered plain read data
    logic [DATA_W-1:0] rdata_d;     // next plain read data
    logic              ram_sel_q;   // previous cycle was a ram read
    logic              ram_sel_d;   // next ram select
    ida_state_e        state_q;     // read phase
    ida_state_e        state_d;     // next read phase

    // =====================================================
    // decode
    ida_mode_e         mode;        // virtual location mode
    logic [1:0]        psel;        // pointer chosen
    logic [ADDR_W-1:0] eff_addr;    // effective data address
    logic              is_virt;     // virtual location hit
    logic [ADDR_W-1:0] ram_addr;    // address to ram
    logic              ram_we;      // ram write
    logic [DATA_W-1:0] ram_rdata;   // ram read data
    logic              tgt_ram;     // target of access is ram
    logic              tgt_sfr;     // target of access is own register

    // map an address onto pointer group and mode
    function automatic ida_mode_e mode_of(input logic [ADDR_W-1:0] a,
                                          input logic [ADDR_W-1:0] base);
        logic [ADDR_W-1:0] d;
        d = a - base;
        mode_of = IDA_MODE_NONE;
        if (a >= base && d <= 12'h004) begin
            mode_of = ida_mode_e'(d[2:0]);
        end
    endfunction

    // location decode, pointer choice and mode
    always_comb begin
        mode = IDA_MODE_NONE;
        psel = 2'h0;
        if (mode_of(addr, `IDA_OFF_GRP0) != IDA_MODE_NONE) begin
            mode = mode_of(addr, `IDA_OFF_GRP0);
            psel = 2'h0;
        end else if (mode_of(addr, `IDA_OFF_GRP1) != IDA_MODE_NONE) begin
            mode = mode_of(addr, `IDA_OFF_GRP1);
            psel = 2'h1;
        end else if (mode_of(addr, `IDA_OFF_GRP2) != IDA_MODE_NONE) begin
            mode = mode_of(addr, `IDA_OFF_GRP2);
            psel = 2'h2;
        end
        is_virt = (mode != IDA_MODE_NONE);
    end

    // effective address per mode
    always_comb begin
        eff_addr = ptr_q[psel];
        if (mode == IDA_MODE_PREINC) begin
            eff_addr = ptr_q[psel] + 12'h001;
        end else if (mode == IDA_MODE_OFFSET) begin
            eff_addr = ptr_q[psel] + {{(ADDR_W-DATA_W){1'b0}}, work_q};
        end
        ram_addr = is_virt ? eff_addr : addr;
        tgt_ram  = (ram_addr < `IDA_OFF_SFR_BASE);
        tgt_sfr  = !tgt_ram;
        ram_we   = wr_stb && tgt_ram;
    end

    // data memory
    ida_mem #(
        .ADDR_W (ADDR_W),
        .DATA_W (DATA_W),
        .DEPTH  (RAM_D)
    ) ida_mem_inst (
        .ref_clk (ref_clk),
        .addr    (ram_addr),
        .wdata   (wdata),
        .we      (ram_we),
        .rdata   (ram_rdata)
    );

    // =====================================================
    // register next values
    always_comb begin
        ptr_d     = ptr_q;
        work_d    = work_q;
        rdata_d   = '0;
        ram_sel_d = 1'b0;
        state_d   = rd_stb ? IDA_ST_READ : IDA_ST_IDLE;
        // target of a read: own register, zero, or ram
        if (rd_stb && tgt_sfr) begin
            if (ram_addr == `IDA_OFF_PTR0_HIGH) begin
                rdata_d = {4'h0, ptr_q[0][11:8]};
            end else if (ram_addr == `IDA_OFF_PTR0_LOW) begin
                rdata_d = ptr_q[0][7:0];
            end else if (ram_addr == `IDA_OFF_WORKING) begin
                rdata_d = work_q;
            end else if (ram_addr == `IDA_OFF_PTR1_HIGH) begin
                rdata_d = {4'h0, ptr_q[1][11:8]};
            end else if (ram_addr == `IDA_OFF_PTR1_LOW) begin
                rdata_d = ptr_q[1][7:0];
            end else if (ram_addr == `IDA_OFF_PTR2_HIGH) begin
                rdata_d = {4'h0, ptr_q[2][11:8]};
            end else if (ram_addr == `IDA_OFF_PTR2_LOW) begin
                rdata_d = ptr_q[2][7:0];
            end else begin
                rdata_d = '0;
            end
        end else if (rd_stb) begin
            ram_sel_d = 1'b1;
        end
        // writes to own registers
        if (wr_stb && tgt_sfr) begin
            if (ram_addr == `IDA_OFF_PTR0_HIGH) begin
                ptr_d[0][11:8] = wdata[3:0];
            end else if (ram_addr == `IDA_OFF_PTR0_LOW) begin
                ptr_d[0][7:0] = wdata;
            end else if (ram_addr == `IDA_OFF_WORKING) begin
                work_d = wdata;
            end else if (ram_addr == `IDA_OFF_PTR1_HIGH) begin
                ptr_d[1][11:8] = wdata[3:0];
            end else if (ram_addr == `IDA_OFF_PTR1_LOW) begin
                ptr_d[1][7:0] = wdata;
            end else if (ram_addr == `IDA_OFF_PTR2_HIGH) begin
                ptr_d[2][11:8] = wdata[3:0];
            end else if (ram_addr == `IDA_OFF_PTR2_LOW) begin
                ptr_d[2][7:0] = wdata;
            end
        end
        // pointer steps after a virtual access, full 12-bit carry and wrap
        if ((rd_stb || wr_stb) && is_virt) begin
            case (mode)
                IDA_MODE_POSTINC: ptr_d[psel] = ptr_q[psel] + 12'h001;
                IDA_MODE_POSTDEC: ptr_d[psel] = ptr_q[psel] - 12'h001;
                IDA_MODE_PREINC:  ptr_d[psel] = ptr_q[psel] + 12'h001;
                default:          ptr_d[psel] = ptr_q[psel];
            endcase
        end
    end

    // registers
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            for (int i = 0; i < 3; i++) begin
                ptr_q[i] <= {`IDA_RST_HIGH, `IDA_RST_LOW};
            end
            work_q    <= `IDA_RST_WORKING;
            rdata_q   <= '0;
            ram_sel_q <= 1'b0;
            state_q   <= IDA_ST_IDLE;
        end else begin
            ptr_q     <= ptr_d;
            work_q    <= work_d;
            rdata_q   <= rdata_d;
            ram_sel_q <= ram_sel_d;
            state_q   <= state_d;
        end
    end

    // =====================================================
    // outputs
    always_comb begin
        rdata = ram_sel_q ? ram_rdata : rdata_q;
    end
    always_comb begin
        ptr0 = ptr_q[0];
        ptr1 = ptr_q[1];
        ptr2 = ptr_q[2];
    end

    // =====================================================
    // checks
    unimpl_zero_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        rd_stb && !is_virt && addr >= `IDA_OFF_SFR_BASE && addr < `IDA_OFF_PTR2_LOW
        |=> rdata == 8'h00) else $error("unimplemented location not zero");
    plain_keep_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (rd_stb || wr_stb) && mode == IDA_MODE_PLAIN
        |-> ram_addr == ptr_q[psel] ##1 ptr_q[$past(psel)] == $past(ptr_q[psel]))
        else $error("plain access moved pointer");
    postinc_step_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (rd_stb || wr_stb) && mode == IDA_MODE_POSTINC
        |=> ptr_q[$past(psel)] == $past(ptr_q[psel]) + 12'h001)
        else $error("post-increment wrong");
    postdec_step_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (rd_stb || wr_stb) && mode == IDA_MODE_POSTDEC
        |-> ram_addr == ptr_q[psel] ##1 ptr_q[$past(psel)] == $past(ptr_q[psel]) - 12'h001)
        else $error("post-decrement wrong");
    preinc_addr_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (rd_stb || wr_stb) && mode == IDA_MODE_PREINC
        |-> ram_addr == ptr_q[psel] + 12'h001 ##1 ptr_q[$past(psel)] == $past(ram_addr))
        else $error("pre-increment wrong");
    offset_addr_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (rd_stb || wr_stb) && mode == IDA_MODE_OFFSET
        |-> ram_addr == ptr_q[psel] + {4'h0, work_q}
        ##1 ptr_q[$past(psel)] == $past(ptr_q[psel]))
        else $error("offset access wrong");
    high_nibble_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        rd_stb && addr == `IDA_OFF_PTR0_HIGH |=> rdata == {4'h0, $past(ptr_q[0][11:8])})
        else $error("pointer high read wrong");
    wrap_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        rd_stb && mode == IDA_MODE_POSTINC && ptr_q[psel] == 12'hfff
        |=> ptr_q[$past(psel)] == 12'h000) else $error("pointer did not wrap");
    postinc_c: cover property (@(posedge ref_clk) rd_stb && mode == IDA_MODE_POSTINC);
    preinc_c:  cover property (@(posedge ref_clk) wr_stb && mode == IDA_MODE_PREINC);
    offset_c:  cover property (@(posedge ref_clk) rd_stb && mode == IDA_MODE_OFFSET);
    // read phase that hands ram data to the cpu
    ram_read_c: cover property (@(posedge ref_clk) state_q == IDA_ST_READ && ram_sel_q);
endmodule

// ---- sim/ida_top_tb_top.sv ----
// Purpose: self-checking bench for the indirect data addressing block
// Assumes: cpu port with one-cycle strobes, read data one cycle after rd_stb
// Notes:   ram contents are written before they are read back
`timescale 1ns/10ps
`include "ida_cfg.svh"
module ida_top_tb_top;
    // =====================================================
    // virtual locations: offset, preinc, postdec, postinc, plain
    localparam logic [11:0] OF0 = `IDA_OFF_GRP0;
    localparam logic [11:0] PR0 = `IDA_OFF_GRP0 + 12'h001;
    localparam logic [11:0] PD0 = `IDA_OFF_GRP0 + 12'h002;
    localparam logic [11:0] PI0 = `IDA_OFF_GRP0 + 12'h003;
    localparam logic [11:0] PL0 = `IDA_OFF_GRP0 + 12'h004;
    localparam logic [11:0] OF1 = `IDA_OFF_GRP1;
    localparam logic [11:0] PR2 = `IDA_OFF_GRP2 + 12'h001;
    localparam logic [11:0] PD2 = `IDA_OFF_GRP2 + 12'h002;
    localparam logic [11:0] PI2 = `IDA_OFF_GRP2 + 12'h003;
    localparam logic [11:0] PL2 = `IDA_OFF_GRP2 + 12'h004;
    logic        ref_clk;   // core clock
    logic        rst_n;     // synchronous reset, active low
    logic [11:0] addr;      // access address
    logic [7:0]  wdata;     // write data
    logic        wr_stb;    // write strobe
    logic        rd_stb;    // read strobe
    logic [7:0]  rdata;     // read data
    logic [11:0] ptr0;      // pointer views
    logic [11:0] ptr1;
    logic [11:0] ptr2;
    int          bad_count; // mismatches seen
    int          n_tests;   // comparisons made
    logic [11:0] unimp[5];  // unimplemented special places

    ida_top ida_top_inst (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .addr    (addr),
        .wdata   (wdata),
        .wr_stb  (wr_stb),
        .rd_stb  (rd_stb),
        .rdata   (rdata),
        .ptr0    (ptr0),
        .ptr1    (ptr1),
        .ptr2    (ptr2)
    );

    // =====================================================
    // clock: 8 ns period
    initial ref_clk = 1'b0;
    always #4 ref_clk = ~ref_clk;

    // =====================================================
    // bus tasks: a write leaves its strobe up, so writes run back to back
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        addr   <= a;
        wdata  <= d;
        wr_stb <= 1'b1;
        rd_stb <= 1'b0;
    endtask
    // lowers strobes at the sampling edge, then lets updates settle
    task automatic idle();
        @(posedge ref_clk);
        wr_stb <= 1'b0;
        rd_stb <= 1'b0;
        #1;
    endtask
    // compare one value and count it
    task automatic chk(input string what, input logic [11:0] seen, input logic [11:0] exp);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // read one byte, data taken in the cycle after the strobe
    task automatic rchk(input logic [11:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        addr   <= a;
        rd_stb <= 1'b1;
        wr_stb <= 1'b0;
        idle();
        chk($sformatf("rdata@%h", a), {4'h0, rdata}, {4'h0, exp});
    endtask
    // load a pointer through its high and low registers
    task automatic set_ptr(input logic [11:0] hi, input logic [11:0] v);
        wr(hi, {4'h0, v[11:8]});
        wr(hi - 12'h001, v[7:0]);
    endtask

    // =====================================================
    // closing task: counts, verdict, end of run
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // watchdog: the tests need about a hundred cycles
    initial begin
        #(8 * 3000);
        bad_count++;
        $display("[FAIL] watchdog expected finish seen hang");
        conclude();
    end

    // =====================================================
    // main sequence
    initial begin
        bad_count = 0;
        n_tests   = 0;
        rst_n     = 1'b0;
        addr      = 12'h000;
        wdata     = 8'h00;
        wr_stb    = 1'b0;
        rd_stb    = 1'b0;
        unimp     = '{12'hf60, 12'hf7f, 12'hfd8, 12'hfe0, 12'hfff};
        repeat (20) @(posedge ref_clk);
        rst_n <= 1'b1;
        // reset values and pointer width
        #1;
        chk("ptr0", ptr0, 12'h000);
        rchk(`IDA_OFF_PTR0_HIGH, 8'h00);
        wr(`IDA_OFF_PTR0_HIGH, 8'hff);
        idle();
        chk("ptr0", ptr0, 12'hf00);
        rchk(`IDA_OFF_PTR0_HIGH, 8'h0f);
        $display("test reset_width done");
        // plain location keeps the pointer
        set_ptr(`IDA_OFF_PTR0_HIGH, 12'h0ff);
        wr(PL0, 8'ha5);
        idle();
        chk("ptr0", ptr0, 12'h0ff);
        rchk(PL0, 8'ha5);
        $display("test plain done");
        // stepping writes, carry across the byte boundary
        wr(PI0, 8'h11);
        wr(PI0, 8'h12);
        idle();
        chk("ptr0", ptr0, 12'h101);
        wr(PD0, 8'h21);
        idle();
        chk("ptr0", ptr0, 12'h100);
        wr(PR0, 8'h31);
        idle();
        chk("ptr0", ptr0, 12'h101);
        rchk(PL0, 8'h31);
        // stepping reads walk back over the same bytes, borrowing across the byte boundary, then forward
        rchk(PD0, 8'h31);
        rchk(PD0, 8'h12);
        chk("ptr0", ptr0, 12'h0ff);
        rchk(PI0, 8'h11);
        rchk(PR0, 8'h31);
        chk("ptr0", ptr0, 12'h101);
        $display("test stepping done");
        // offset by working register, read and write
        set_ptr(`IDA_OFF_PTR1_HIGH, 12'h0fe);
        wr(`IDA_OFF_WORKING, 8'h03);
        idle();
        rchk(OF1, 8'h31);
        wr(OF1, 8'h55);
        idle();
        chk("ptr1", ptr1, 12'h0fe);
        rchk(PL0, 8'h55);
        // offset write carries into the high nibble: 0x101 + 0xff lands on 0x200
        wr(`IDA_OFF_WORKING, 8'hff);
        wr(OF0, 8'h66);
        idle();
        chk("ptr0", ptr0, 12'h101);
        set_ptr(`IDA_OFF_PTR2_HIGH, 12'h200);
        rchk(PL2, 8'h66);
        rchk(OF0, 8'h66);
        $display("test offset done");
        // wrap at the top of the address range
        set_ptr(`IDA_OFF_PTR2_HIGH, 12'hfff);
        rchk(PI2, 8'h00);
        chk("ptr2", ptr2, 12'h000);
        wr(PD2, 8'h44);
        idle();
        chk("ptr2", ptr2, 12'hfff);
        rchk(PR2, 8'h44);
        rchk(`IDA_OFF_PTR2_LOW, 8'h00);
        $display("test wrap done");
        // unimplemented special places ignore writes and read zero
        foreach (unimp[i]) begin
            wr(unimp[i], 8'hff);
        end
        idle();
        foreach (unimp[i]) begin
            rchk(unimp[i], 8'h00);
        end
        chk("ptr1", ptr1, 12'h0fe);
        $display("test unimplemented done");
        conclude();
    end
endmodule
